// *** verilog/cepvm_pkg.sv ***
// constants for the exception priority, vector and mask unit
// assumes a 32-bit Avalon-MM register port with byte addresses
`default_nettype none
package cepvm_pkg;
	// register byte offsets
	localparam logic [7:0]  OFF_STATWORD   = 8'h00;
	localparam logic [7:0]  OFF_INT_BASE   = 8'h04;
	localparam logic [7:0]  OFF_EXC_BASE   = 8'h08;
	localparam logic [7:0]  OFF_FAST       = 8'h0C;
	localparam logic [7:0]  OFF_STATUS     = 8'h10;
	localparam logic [7:0]  OFF_MASK       = 8'h14;
	localparam logic [7:0]  OFF_CAUSE      = 8'h18;
	// processor status word fields
	localparam int          SW_ENABLE_BIT  = 16;
	localparam int          SW_LEVEL_LSB   = 24;
	localparam logic        ENABLE_RESET   = 1'h1;
	localparam logic [3:0]  LEVEL_RESET    = 4'h0;
	localparam logic [31:0] BASE_RESET     = 32'h00000000;
	localparam logic [2:0]  EVT_RESET      = 3'h0;
	// event bits of status and mask
	localparam int          EVT_ACCEPT     = 0;
	localparam int          EVT_NMI        = 1;
	localparam int          EVT_FAULT      = 2;
	// fixed reset vector location
	localparam logic [31:0] RESET_VECTOR   = 32'hFFFFFFFC;
	// cause codes, highest priority first
	localparam logic [3:0]  C_RESET        = 4'h0;
	localparam logic [3:0]  C_NMI          = 4'h1;
	localparam logic [3:0]  C_IRQ          = 4'h2;
	localparam logic [3:0]  C_FAST         = 4'h3;
	localparam logic [3:0]  C_IACCESS      = 4'h4;
	localparam logic [3:0]  C_UNDEF        = 4'h5;
	localparam logic [3:0]  C_PRIV         = 4'h6;
	localparam logic [3:0]  C_TRAP         = 4'h7;
	localparam logic [3:0]  C_ADDR         = 4'h8;
	localparam logic [3:0]  C_OACCESS      = 4'h9;
	localparam logic [3:0]  C_FPU          = 4'hA;
	localparam logic [3:0]  C_NONE         = 4'hF;
	// exception table vector numbers
	localparam logic [7:0]  V_NMI          = 8'h1E;
	localparam logic [7:0]  V_IACCESS      = 8'h15;
	localparam logic [7:0]  V_UNDEF        = 8'h17;
	localparam logic [7:0]  V_PRIV         = 8'h14;
	localparam logic [7:0]  V_ADDR         = 8'h1C;
	localparam logic [7:0]  V_OACCESS      = 8'h16;
	localparam logic [7:0]  V_FPU          = 8'h19;
	// fsm states
	typedef enum logic [2:0] {
		S_IDLE  = 3'b001,
		S_FETCH = 3'b010,
		S_DONE  = 3'b100
	} cepvm_state_t;
endpackage : cepvm_pkg
`default_nettype wire

// *** verilog/cepvm_unit.sv ***
// exception acceptance: priority, vector formation, interrupt masking
// assumes a core holding each request until handler_valid and a
// memory port that returns fetch_valid with fetch_data
`timescale 1ns/1ps
`default_nettype none

module cepvm_unit (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output var  logic [31:0] readdata,
	output var  logic        waitrequest,
	output var  logic        irq,
	input  wire logic        reset_request,
	input  wire logic        nmi_request,
	input  wire logic        irq_request,
	input  wire logic [3:0]  irq_level,
	input  wire logic [7:0]  irq_vector,
	input  wire logic        irq_fast,
	input  wire logic        iaccess_request,
	input  wire logic        undef_request,
	input  wire logic        priv_request,
	input  wire logic        trap_request,
	input  wire logic [3:0]  trap_number,
	input  wire logic        addr_request,
	input  wire logic        oaccess_request,
	input  wire logic        fpu_request,
	output var  logic        fetch_read,
	output var  logic [31:0] fetch_address,
	input  wire logic        fetch_valid,
	input  wire logic [31:0] fetch_data,
	output var  logic        handler_valid,
	output var  logic [31:0] handler_address,
	output var  logic [3:0]  handler_cause
);
	cepvm_pkg::cepvm_state_t state;
	cepvm_pkg::cepvm_state_t next_state;
	logic        int_enable;
	logic [3:0]  priority_mask_level;
	logic [31:0] interrupt_table_base;
	logic [31:0] exception_table_base;
	logic [31:0] fast_vector;
	logic [2:0]  status;
	logic [2:0]  mask;
	logic        next_int_enable;
	logic [3:0]  next_priority_mask_level;
	logic [31:0] next_interrupt_table_base;
	logic [31:0] next_exception_table_base;
	logic [31:0] next_fast;
	logic [2:0]  next_status;
	logic [2:0]  next_mask;
	logic [31:0] next_readdata;
	logic        next_waitrequest;
	logic        next_irq;
	logic        next_fetch_read;
	logic [31:0] next_fetch_address;
	logic        next_handler_valid;
	logic [31:0] next_handler_address;
	logic [3:0]  next_handler_cause;
	logic        irq_ok;
	logic [3:0]  pick;
	logic        take;
	logic        commit;
	logic [31:0] processor_status_word;

	// merges enabled byte lanes of a write into an old value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				r[8*i +: 8] = wd[8*i +: 8];
		end
		return r;
	endfunction : merge

	// table entry address: base plus vector number times four
	function automatic logic [31:0] entry(input logic [31:0] base, input logic [7:0] vec);
		return base + {22'h000000, vec, 2'h0};
	endfunction : entry

	assign processor_status_word = {4'h0, priority_mask_level, 7'h00, int_enable, 16'h0000};
	// interrupt qualified by enable bit and strict level compare
	assign irq_ok = irq_request && int_enable
		&& (irq_level > priority_mask_level);
	assign take   = (state == cepvm_pkg::S_IDLE) && (pick != cepvm_pkg::C_NONE);
	assign commit = (read || write) && !waitrequest;

	always_comb
	begin
		// fixed order, highest first
		if (reset_request)
			pick = cepvm_pkg::C_RESET;
		else if (nmi_request)
			pick = cepvm_pkg::C_NMI;
		else if (irq_ok)
			pick = irq_fast ? cepvm_pkg::C_FAST : cepvm_pkg::C_IRQ;
		else if (iaccess_request)
			pick = cepvm_pkg::C_IACCESS;
		else if (undef_request)
			pick = cepvm_pkg::C_UNDEF;
		else if (priv_request)
			pick = cepvm_pkg::C_PRIV;
		else if (trap_request)
			pick = cepvm_pkg::C_TRAP;
		else if (addr_request)
			pick = cepvm_pkg::C_ADDR;
		else if (oaccess_request)
			pick = cepvm_pkg::C_OACCESS;
		else if (fpu_request)
			pick = cepvm_pkg::C_FPU;
		else
			pick = cepvm_pkg::C_NONE;
	end

	always_comb
	begin
		next_state           = state;
		next_int_enable      = int_enable;
		next_priority_mask_level  = priority_mask_level;
		next_interrupt_table_base = interrupt_table_base;
		next_exception_table_base = exception_table_base;
		next_fast            = fast_vector;
		next_status          = status;
		next_mask            = mask;
		next_readdata        = readdata;
		next_waitrequest     = 1'h1;
		next_fetch_read      = fetch_read;
		next_fetch_address   = fetch_address;
		next_handler_valid   = 1'h0;
		next_handler_address = handler_address;
		next_handler_cause   = handler_cause;
		// bus: waitrequest drops one cycle after a request is seen
		if ((read || write) && waitrequest)
			next_waitrequest = 1'h0;
		// loaded when the request is seen, so it stands while waitrequest is low
		if (read && !write && waitrequest)
		begin
			case (address)
				cepvm_pkg::OFF_STATWORD: next_readdata = processor_status_word;
				cepvm_pkg::OFF_INT_BASE: next_readdata = interrupt_table_base;
				cepvm_pkg::OFF_EXC_BASE: next_readdata = exception_table_base;
				cepvm_pkg::OFF_FAST:   next_readdata = fast_vector;
				cepvm_pkg::OFF_STATUS: next_readdata = {29'h00000000, status};
				cepvm_pkg::OFF_MASK:   next_readdata = {29'h00000000, mask};
				cepvm_pkg::OFF_CAUSE:  next_readdata = {28'h0000000, handler_cause};
				default:               next_readdata = 32'h00000000;
			endcase
		end
		if (commit && write)
		begin
			case (address)
				cepvm_pkg::OFF_STATWORD:
				begin
					if (byteenable[2])
						next_int_enable = writedata[cepvm_pkg::SW_ENABLE_BIT];
					if (byteenable[3])
						next_priority_mask_level = writedata[cepvm_pkg::SW_LEVEL_LSB +: 4];
				end
				cepvm_pkg::OFF_INT_BASE:
					next_interrupt_table_base = merge(interrupt_table_base, writedata, byteenable);
				cepvm_pkg::OFF_EXC_BASE:
					next_exception_table_base = merge(exception_table_base, writedata, byteenable);
				cepvm_pkg::OFF_FAST:   next_fast = merge(fast_vector, writedata, byteenable);
				cepvm_pkg::OFF_STATUS:
				begin
					if (byteenable[0])
						next_status = status & ~writedata[2:0];
				end
				cepvm_pkg::OFF_MASK:
				begin
					if (byteenable[0])
						next_mask = writedata[2:0];
				end
				default:               next_mask = mask;
			endcase
		end
		case (state)
			cepvm_pkg::S_IDLE:
			begin
				if (take)
				begin
					next_int_enable    = 1'h0;
					next_handler_cause = pick;
					next_status[cepvm_pkg::EVT_ACCEPT] = 1'h1;
					if (pick == cepvm_pkg::C_NMI)
						next_status[cepvm_pkg::EVT_NMI] = 1'h1;
					if (pick >= cepvm_pkg::C_IACCESS && pick != cepvm_pkg::C_TRAP)
						next_status[cepvm_pkg::EVT_FAULT] = 1'h1;
					next_fetch_read = 1'h1;
					next_state      = cepvm_pkg::S_FETCH;
					case (pick)
						cepvm_pkg::C_RESET:   next_fetch_address = cepvm_pkg::RESET_VECTOR;
						cepvm_pkg::C_NMI:     next_fetch_address = entry(exception_table_base, cepvm_pkg::V_NMI);
						cepvm_pkg::C_IRQ:     next_fetch_address = entry(interrupt_table_base, irq_vector);
						cepvm_pkg::C_TRAP:
							next_fetch_address = entry(interrupt_table_base, {4'h0, trap_number});
						cepvm_pkg::C_IACCESS:
							next_fetch_address = entry(exception_table_base, cepvm_pkg::V_IACCESS);
						cepvm_pkg::C_UNDEF:   next_fetch_address = entry(exception_table_base, cepvm_pkg::V_UNDEF);
						cepvm_pkg::C_PRIV:    next_fetch_address = entry(exception_table_base, cepvm_pkg::V_PRIV);
						cepvm_pkg::C_ADDR:    next_fetch_address = entry(exception_table_base, cepvm_pkg::V_ADDR);
						cepvm_pkg::C_OACCESS: next_fetch_address = entry(exception_table_base, cepvm_pkg::V_OACCESS);
						cepvm_pkg::C_FPU:     next_fetch_address = entry(exception_table_base, cepvm_pkg::V_FPU);
						default:
						begin
							// fast interrupt: no table read
							next_fetch_read      = 1'h0;
							next_handler_address = fast_vector;
							next_handler_valid   = 1'h1;
							next_state           = cepvm_pkg::S_DONE;
						end
					endcase
				end
			end
			cepvm_pkg::S_FETCH:
			begin
				if (fetch_valid)
				begin
					next_fetch_read      = 1'h0;
					next_handler_address = fetch_data;
					next_handler_valid   = 1'h1;
					next_state           = cepvm_pkg::S_DONE;
				end
			end
			cepvm_pkg::S_DONE:
				next_state = cepvm_pkg::S_IDLE;
			default:
				next_state = cepvm_pkg::S_IDLE;
		endcase
		next_irq = |(next_status & next_mask);
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			state           <= cepvm_pkg::S_IDLE;
			int_enable      <= cepvm_pkg::ENABLE_RESET;
			priority_mask_level  <= cepvm_pkg::LEVEL_RESET;
			interrupt_table_base <= cepvm_pkg::BASE_RESET;
			exception_table_base <= cepvm_pkg::BASE_RESET;
			fast_vector     <= cepvm_pkg::BASE_RESET;
			status          <= cepvm_pkg::EVT_RESET;
			mask            <= cepvm_pkg::EVT_RESET;
			readdata        <= 32'h00000000;
			waitrequest     <= 1'h1;
			irq             <= 1'h0;
			fetch_read      <= 1'h0;
			fetch_address   <= 32'h00000000;
			handler_valid   <= 1'h0;
			handler_address <= 32'h00000000;
			handler_cause   <= cepvm_pkg::C_NONE;
		end
		else
		begin
			state           <= next_state;
			int_enable      <= next_int_enable;
			priority_mask_level  <= next_priority_mask_level;
			interrupt_table_base <= next_interrupt_table_base;
			exception_table_base <= next_exception_table_base;
			fast_vector     <= next_fast;
			status          <= next_status;
			mask            <= next_mask;
			readdata        <= next_readdata;
			waitrequest     <= next_waitrequest;
			irq             <= next_irq;
			fetch_read      <= next_fetch_read;
			fetch_address   <= next_fetch_address;
			handler_valid   <= next_handler_valid;
			handler_address <= next_handler_address;
			handler_cause   <= next_handler_cause;
		end
	end

	a_take_clears_ie: assert property (@(posedge clock) disable iff (!resetn)
		take && !(commit && write && address == cepvm_pkg::OFF_STATWORD) |=> !int_enable)
		else $error("enable bit not cleared on acceptance");
	a_irq_level_gate: assert property (@(posedge clock) disable iff (!resetn)
		take && (pick == cepvm_pkg::C_IRQ || pick == cepvm_pkg::C_FAST)
			|-> int_enable && irq_level > priority_mask_level)
		else $error("interrupt taken without enable or level");
	a_nmi_over_irq: assert property (@(posedge clock) disable iff (!resetn)
		take && nmi_request && !reset_request |-> pick == cepvm_pkg::C_NMI)
		else $error("nmi lost priority");
	a_fast_branch: assert property (@(posedge clock) disable iff (!resetn)
		take && pick == cepvm_pkg::C_FAST
			|=> handler_valid && !fetch_read && handler_address == $past(fast_vector))
		else $error("fast interrupt did not branch to fast vector");
	a_reset_fixed: assert property (@(posedge clock) disable iff (!resetn)
		take && pick == cepvm_pkg::C_RESET
			|=> fetch_read && fetch_address == cepvm_pkg::RESET_VECTOR)
		else $error("reset vector not fixed");
	a_exc_table: assert property (@(posedge clock) disable iff (!resetn)
		take && pick == cepvm_pkg::C_FPU
			|=> fetch_address == $past(exception_table_base) + 32'h00000064)
		else $error("fpu vector not from exception table");
	a_trap_table: assert property (@(posedge clock) disable iff (!resetn)
		take && pick == cepvm_pkg::C_TRAP
			|=> fetch_address == $past(interrupt_table_base) + {26'h0, $past(trap_number), 2'h0})
		else $error("trap vector not from interrupt table");
	a_level_write: assert property (@(posedge clock) disable iff (!resetn)
		commit && write && address == cepvm_pkg::OFF_STATWORD && byteenable[3]
			|=> priority_mask_level == $past(writedata[27:24]))
		else $error("mask level write lost");
	a_blocked_idle: assert property (@(posedge clock) disable iff (!resetn)
		!int_enable && !reset_request && !nmi_request && !iaccess_request && !undef_request
			&& !priv_request && !trap_request && !addr_request && !oaccess_request
			&& !fpu_request |-> !take)
		else $error("interrupt taken while disabled");
	a_wait_one: assert property (@(posedge clock) disable iff (!resetn)
		(read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
		else $error("bus answer not one cycle");
endmodule : cepvm_unit

`default_nettype wire

// *** verif/cepvm_far_model.sv ***
// interrupt controller and vector memory beside the exception unit
// assumes the bench pulses src_event and sets a level for each source
`timescale 1ns/1ps
`default_nettype none
module cepvm_far_model (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic [3:0]  src_event,
	input  wire logic [15:0] src_level,
	input  wire logic        handler_valid,
	input  wire logic [3:0]  handler_cause,
	input  wire logic        fetch_read,
	input  wire logic [31:0] fetch_address,
	output var  logic        irq_request,
	output var  logic [3:0]  irq_level,
	output var  logic [7:0]  irq_vector,
	output var  logic        irq_fast,
	output var  logic        fetch_valid,
	output var  logic [31:0] fetch_data
);
	logic [3:0] flag;
	logic [1:0] sel;
	logic [1:0] dly;
	logic [1:0] wcnt;
	// one request shown: highest level wins, lower index on a tie
	always_comb
	begin
		sel = 2'h0;
		for (int i = 3; i >= 0; i--)
			if (flag[i] && (!flag[sel] || src_level[i*4+:4] >= src_level[sel*4+:4]))
				sel = i[1:0];
	end
	assign irq_request = |flag;
	assign irq_level = src_level[sel*4+:4];
	assign irq_vector = 8'h40 + {6'h0, sel};
	assign irq_fast = (sel == 2'h3);
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			flag <= 4'h0;
			fetch_valid <= 1'b0;
			fetch_data <= 32'h0;
			dly <= 2'h0;
			wcnt <= 2'h0;
		end
		else
		begin
			// an event sets its flag until the unit takes it
			if (handler_valid && (handler_cause == cepvm_pkg::C_IRQ
				|| handler_cause == cepvm_pkg::C_FAST))
				flag <= (flag & ~(4'h1 << sel)) | src_event;
			else
				flag <= flag | src_event;
			// memory answers after 0 to 3 cycles, junk data otherwise
			if (fetch_read && !fetch_valid && wcnt == dly)
			begin
				fetch_valid <= 1'b1;
				fetch_data <= fetch_address ^ 32'hA5A5A5A5;
				wcnt <= 2'h0;
				dly <= dly + 2'h1;
			end
			else
			begin
				fetch_valid <= 1'b0;
				fetch_data <= ~fetch_data;
				wcnt <= fetch_read ? wcnt + 2'h1 : 2'h0;
			end
		end
	end
endmodule : cepvm_far_model
`default_nettype wire

// *** verif/cpu_exception_priority_vector_mask_test.sv ***
// self-checking bench for the exception priority, vector and mask unit
// assumes cepvm_far_model as interrupt controller and vector memory
`timescale 1ns/1ps
`default_nettype none
module cpu_exception_priority_vector_mask_test;
	logic clock, resetn, read, write, waitrequest, irq, fetch_read, fetch_valid;
	logic handler_valid, irq_request, irq_fast, en;
	logic [7:0] address, irq_vector;
	logic [31:0] writedata, readdata, fetch_address, fetch_data, handler_address, q, d;
	logic [3:0] handler_cause, irq_level, trap_number, src_event, priority_mask_level;
	logic [15:0] src_level, rnd;
	logic [8:0] req;
	logic [31:0] base [4];
	int num_errors, checks;
	localparam logic [3:0] CZ [9] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA};
	localparam logic [7:0] VN [9] = '{8'h0, cepvm_pkg::V_NMI, cepvm_pkg::V_IACCESS,
		cepvm_pkg::V_UNDEF, cepvm_pkg::V_PRIV, 8'h0, cepvm_pkg::V_ADDR,
		cepvm_pkg::V_OACCESS, cepvm_pkg::V_FPU};
	cepvm_unit uut (.clock(clock), .resetn(resetn), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
		.waitrequest(waitrequest), .irq(irq), .reset_request(req[0]),
		.nmi_request(req[1]), .irq_request(irq_request), .irq_level(irq_level),
		.irq_vector(irq_vector), .irq_fast(irq_fast), .iaccess_request(req[2]),
		.undef_request(req[3]), .priv_request(req[4]), .trap_request(req[5]),
		.trap_number(trap_number), .addr_request(req[6]), .oaccess_request(req[7]),
		.fpu_request(req[8]), .fetch_read(fetch_read), .fetch_address(fetch_address),
		.fetch_valid(fetch_valid), .fetch_data(fetch_data), .handler_valid(handler_valid),
		.handler_address(handler_address), .handler_cause(handler_cause));
	cepvm_far_model far (.clock(clock), .resetn(resetn), .src_event(src_event),
		.src_level(src_level), .handler_valid(handler_valid), .handler_cause(handler_cause),
		.fetch_read(fetch_read), .fetch_address(fetch_address), .irq_request(irq_request),
		.irq_level(irq_level), .irq_vector(irq_vector), .irq_fast(irq_fast),
		.fetch_valid(fetch_valid), .fetch_data(fetch_data));
	always #2.5 clock = ~clock;
	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nxt
	task automatic finish_test();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// holds the request until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clock);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= wd;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (waitrequest !== 1'b0 && n < 50);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		check("bus answer", 32'h1, n < 50);
	endtask : bus
	// {request index, cause, vector address} of the source due next
	function automatic logic [39:0] expect_next();
		for (int i = 0; i < 9; i++)
		begin
			if (i == 2 && irq_request === 1'b1 && en && irq_level > priority_mask_level)
				return {4'hF, irq_fast ? {cepvm_pkg::C_FAST, base[3]}
					: {cepvm_pkg::C_IRQ, base[1] + {irq_vector, 2'b00}}};
			if (req[i])
				return {i[3:0], CZ[i], i == 0 ? cepvm_pkg::RESET_VECTOR : i == 5
					? base[1] + {trap_number, 2'b00} : base[2] + {VN[i], 2'b00}};
		end
		return {4'hF, cepvm_pkg::C_NONE, 32'h0};
	endfunction : expect_next
	task automatic round();
		logic [39:0] e;
		int n;
		for (int k = 0; k < 12; k++)
		begin
			@(negedge clock);
			e = expect_next();
			n = 0;
			while (handler_valid !== 1'b1 && n < 60)
			begin
				@(negedge clock);
				n++;
			end
			if (e[35:32] == cepvm_pkg::C_NONE)
			begin
				check("refused", 32'h0, n < 60);
				return;
			end
			check("cause", e[35:32], handler_cause);
			check("handler", e[35:32] == cepvm_pkg::C_FAST ? e[31:0] : e[31:0] ^ 32'hA5A5A5A5,
				handler_address);
			@(posedge clock);
			req <= req & ~(9'h1 << e[39:36]);
			en = 1'b0;
		end
	endtask : round
	task automatic set_status_word(input logic e_bit, input logic [3:0] lvl);
		en = e_bit;
		priority_mask_level = lvl;
		d = {4'h0, lvl, 7'h0, e_bit, 16'h0};
		bus(1'b1, cepvm_pkg::OFF_STATWORD, d);
		bus(1'b0, cepvm_pkg::OFF_STATWORD, 32'h0);
		check("status word", d, q);
	endtask : set_status_word
	task automatic pulse(input logic [3:0] s);
		@(posedge clock);
		src_event <= s;
		@(posedge clock);
		src_event <= 4'h0;
		repeat (2) @(posedge clock);
	endtask : pulse
	initial
	begin
		#100000;
		num_errors++;
		finish_test();
	end
	initial
	begin
		{clock, read, write, address, writedata, req, trap_number, src_event} = '0;
		resetn = 1'b0;
		rnd = 16'hCC9C;
		src_level = 16'h1111;
		en = 1'b1;
		priority_mask_level = 4'h0;
		repeat (8) @(posedge clock);
		resetn <= 1'b1;
		bus(1'b0, cepvm_pkg::OFF_STATWORD, 32'h0);
		check("status word reset", 32'h1 << cepvm_pkg::SW_ENABLE_BIT, q);
		for (int i = 1; i < 4; i++)
		begin
			rnd = nxt(rnd);
			base[i] = {rnd, ~rnd} & 32'hFFFFFFFC;
			bus(1'b1, 8'(i * 4), base[i]);
			bus(1'b0, 8'(i * 4), 32'h0);
			check("base", base[i], q);
		end
		bus(1'b0, 8'h20, 32'h0);
		check("unmapped", 32'h0, q);
		bus(1'b1, cepvm_pkg::OFF_MASK, 32'h1);
		rnd = nxt(rnd);
		src_level <= rnd | 16'h1111;
		trap_number <= rnd[3:0];
		// block interrupts first, so the pending request waits behind the round
		set_status_word(1'b0, 4'h0);
		pulse(4'h1);
		req <= 9'h1FF;
		round();
		check("irq raised", 32'h1, irq);
		bus(1'b1, cepvm_pkg::OFF_STATUS, 32'h7);
		repeat (2) @(negedge clock);
		check("irq cleared", 32'h0, irq);
		for (int k = 0; k < 4; k++)
		begin
			if (k == 0 || k == 3)
				pulse(k == 0 ? 4'h2 : 4'h8);
			set_status_word(k == 0, k == 0 ? irq_level : k == 1 ? 4'h0 : irq_level - 4'h1);
			if (k > 1)
			begin
				// enable last, so the acceptance follows the expectation
				en = 1'b1;
				bus(1'b1, cepvm_pkg::OFF_STATWORD, d | (32'h1 << cepvm_pkg::SW_ENABLE_BIT));
			end
			round();
		end
		finish_test();
	end
endmodule : cpu_exception_priority_vector_mask_test
`default_nettype wire
